/* hw/sdsr_map.svh */
// sdsr_map.svh: offsets, field positions, reset values and codes for the
// signal detect status reporting block.
// assumes: included by bare name from the package and the top module.
`ifndef SDSR_MAP_SVH
`define SDSR_MAP_SVH

// detector layout
`define SDSR_NUM_OUT 6
`define SDSR_CHAN_FIRST 8'h01
`define SDSR_CHAN_LAST 8'h06

// questionable condition bit positions
`define SDSR_QC_INPUT_BIT 9
`define SDSR_QC_OUTPUT_BIT 10

// questionable enable: legal range and the bits that take effect
`define SDSR_QE_MAX 32'h0000_7fff
`define SDSR_QE_NUMERIC_MAX 32'h0000_ffff
`define SDSR_QE_LIVE_BITS 16'h0600
`define SDSR_QE_RESET 16'h0000
`define SDSR_OE_RESET 16'h0000

// error queue
`define SDSR_ERRQ_DEPTH 30

// error codes, 16-bit two's complement
`define SDSR_CODE_BAD_CHAR 16'hff9b
`define SDSR_CODE_SYNTAX 16'hff9a
`define SDSR_CODE_BAD_SEP 16'hff99
`define SDSR_CODE_MISSING_PARAM 16'hff93
`define SDSR_CODE_BAD_HEADER 16'hff8f
`define SDSR_CODE_NUM_OVERFLOW 16'hff85
`define SDSR_CODE_OUT_OF_RANGE 16'hff22
`define SDSR_CODE_QUEUE_OVERFLOW 16'hfea2

// version reply, value arbitrary
`define SDSR_VERSION_DFLT 32'h0000_0001

`endif

/* hw/sdsr_pkg.sv */
// sdsr_pkg: types shared by the status reporting block and its bench.
// assumes: sdsr_map.svh is on the include path.
package sdsr_pkg;
    `include "sdsr_map.svh"

    // decoded commands handed over by the text parser
    typedef enum logic [3:0] {
        SDSR_OP_OUT_DET_Q, SDSR_OP_OPER_COND_Q, SDSR_OP_OPER_EVENT_Q,
        SDSR_OP_OPER_ENAB_SET, SDSR_OP_OPER_ENAB_Q, SDSR_OP_PRESET,
        SDSR_OP_QUES_COND_Q, SDSR_OP_QUES_EVENT_Q, SDSR_OP_QUES_ENAB_SET,
        SDSR_OP_QUES_ENAB_Q, SDSR_OP_ERR_Q, SDSR_OP_VERS_Q,
        SDSR_OP_CLEAR_STATUS
    } sdsr_op_e;

    // error kinds kept in the queue; the code is derived from the kind
    typedef enum logic [3:0] {
        SDSR_ERR_NONE, SDSR_ERR_BAD_CHAR, SDSR_ERR_SYNTAX, SDSR_ERR_BAD_SEP,
        SDSR_ERR_MISSING_PARAM, SDSR_ERR_BAD_HEADER, SDSR_ERR_NUM_OVERFLOW,
        SDSR_ERR_OUT_OF_RANGE, SDSR_ERR_QUEUE_OVERFLOW
    } sdsr_err_e;

    typedef struct packed {
        sdsr_op_e op;
        logic chan_given;
        logic [7:0] chan;
        logic param_given;
        logic [31:0] param;
    } sdsr_cmd_s;

    typedef struct packed {
        logic [31:0] value;
        logic is_error;
        logic [15:0] err_code;
        sdsr_err_e err_kind;
    } sdsr_rsp_s;
endpackage

/* hw/sdsr_top.sv */
// sdsr_top: status reporting for a six-output distribution amplifier.
// assumes: an upstream text parser hands over one decoded command or one
// parse error per cycle on SYS_CLK; detector levels arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "sdsr_map.svh"

module sdsr_top
    import sdsr_pkg::*;
#(
    parameter int NUM_OUT = `SDSR_NUM_OUT,
    parameter int ERRQ_DEPTH = `SDSR_ERRQ_DEPTH,
    parameter logic [31:0] VERSION = `SDSR_VERSION_DFLT
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // detector levels, asynchronous, high means no signal
    input wire logic IN_LOSS,
    input wire logic [NUM_OUT-1:0] OUT_LOSS,
    // decoded commands from the parser
    input wire logic CMD_VALID,
    input wire sdsr_cmd_s CMD,
    // parse errors from the parser
    input wire logic PERR_VALID,
    input wire sdsr_err_e PERR_KIND,
    // high while the cause of the oldest queued error still exists
    input wire logic ERR_COND_HOLD,
    // replies to queries
    output logic RSP_VALID,
    output sdsr_rsp_s RSP,
    // status byte bit 3 summary and queue state
    output logic QUES_SUMMARY,
    output logic ERR_QUEUE_EMPTY,
    output logic [5:0] ERR_COUNT
);

    localparam int PW = $clog2(ERRQ_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // detector synchronisers

    logic in_meta_r;
    logic in_sync_r;
    logic [NUM_OUT-1:0] out_meta_r;
    logic [NUM_OUT-1:0] out_sync_r;
    logic [NUM_OUT-1:0] out_det;
    logic [15:0] ques_cond;

    // two flops per level; only the second flop feeds logic
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            in_meta_r <= 1'b0;
            in_sync_r <= 1'b0;
            out_meta_r <= '0;
            out_sync_r <= '0;
        end else begin
            in_meta_r <= IN_LOSS;
            in_sync_r <= in_meta_r;
            out_meta_r <= OUT_LOSS;
            out_sync_r <= out_meta_r;
        end
    end

    // a dead input starves every output detector, so all report loss
    assign out_det = out_sync_r | {NUM_OUT{in_sync_r}};

    // live condition word, recomputed every cycle, nothing held
    always_comb begin
        ques_cond = 16'h0000;
        ques_cond[`SDSR_QC_OUTPUT_BIT] = |out_det;
        ques_cond[`SDSR_QC_INPUT_BIT] = in_sync_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode

    logic take;
    logic chan_ok;
    logic param_bad;
    logic param_big;
    logic cmd_err;
    sdsr_err_e cmd_err_kind;
    logic ques_set;
    logic oper_set;
    logic preset;
    logic clear_status;
    logic ques_event_read;
    logic err_read;

    assign take = CMD_VALID && !PERR_VALID;
    // a channel outside 1..6 is rejected with a range error
    assign chan_ok = !CMD.chan_given ||
                     (CMD.chan >= `SDSR_CHAN_FIRST &&
                      CMD.chan <= `SDSR_CHAN_LAST);
    assign param_big = CMD.param > `SDSR_QE_NUMERIC_MAX;
    assign param_bad = CMD.param > `SDSR_QE_MAX;

    // error checks per command; a failing command changes no setting and only queues its error
    always_comb begin
        cmd_err = 1'b0;
        cmd_err_kind = SDSR_ERR_NONE;
        case (CMD.op)
            SDSR_OP_OUT_DET_Q: begin
                if (!chan_ok) begin
                    cmd_err = 1'b1;
                    cmd_err_kind = SDSR_ERR_OUT_OF_RANGE;
                end
            end
            SDSR_OP_QUES_ENAB_SET, SDSR_OP_OPER_ENAB_SET: begin
                if (!CMD.param_given) begin
                    cmd_err = 1'b1;
                    cmd_err_kind = SDSR_ERR_MISSING_PARAM;
                end else if (param_big) begin
                    cmd_err = 1'b1;
                    cmd_err_kind = SDSR_ERR_NUM_OVERFLOW;
                end else if (param_bad) begin
                    cmd_err = 1'b1;
                    cmd_err_kind = SDSR_ERR_OUT_OF_RANGE;
                end
            end
            default: begin
                cmd_err = 1'b0;
            end
        endcase
    end

    assign ques_set = take && !cmd_err && CMD.op == SDSR_OP_QUES_ENAB_SET;
    assign oper_set = take && !cmd_err && CMD.op == SDSR_OP_OPER_ENAB_SET;
    assign preset = take && CMD.op == SDSR_OP_PRESET;
    assign clear_status = take && CMD.op == SDSR_OP_CLEAR_STATUS;
    assign ques_event_read = take && CMD.op == SDSR_OP_QUES_EVENT_Q;
    assign err_read = take && CMD.op == SDSR_OP_ERR_Q;

    ////////////////////////////////////////////////////////////////////////
    // enable masks

    logic [15:0] ques_enab_r;
    logic [15:0] oper_enab_r;

    // questionable mask: bit 15 is never stored, range checked above
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ques_enab_r <= `SDSR_QE_RESET;
        end else if (preset) begin
            ques_enab_r <= 16'h0000;
        end else if (ques_set) begin
            ques_enab_r <= {1'b0, CMD.param[14:0]};
        end
    end

    // operation mask: kept for read-back only, steers nothing
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            oper_enab_r <= `SDSR_OE_RESET;
        end else if (preset) begin
            oper_enab_r <= 16'h0000;
        end else if (oper_set) begin
            oper_enab_r <= CMD.param[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // questionable event register and summary

    logic [15:0] ques_cond_d_r;
    logic [15:0] ques_event_r;
    logic [15:0] ques_rise;

    assign ques_rise = ques_cond & ~ques_cond_d_r;

    // a rise in the clearing cycle survives: set wins over clear
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ques_cond_d_r <= 16'h0000;
            ques_event_r <= 16'h0000;
        end else begin
            ques_cond_d_r <= ques_cond;
            if (ques_event_read || clear_status) begin
                ques_event_r <= ques_rise;
            end else begin
                ques_event_r <= ques_event_r | ques_rise;
            end
        end
    end

    // only bits 10 and 9 can reach the status byte
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            QUES_SUMMARY <= 1'b0;
        end else begin
            QUES_SUMMARY <= |(ques_event_r & ques_enab_r &
                              `SDSR_QE_LIVE_BITS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error queue

    sdsr_err_e errq_mem [ERRQ_DEPTH];
    logic [PW-1:0] rd_ptr_r;
    logic [PW-1:0] wr_ptr_r;
    logic [5:0] count_r;
    logic push;
    sdsr_err_e push_kind;
    logic pop;
    logic push_ok;
    logic full;
    logic [PW-1:0] last_ptr;

    // parser errors take priority; the parser never sends both at once
    assign push = PERR_VALID || (take && cmd_err);
    assign push_kind = PERR_VALID ? PERR_KIND : cmd_err_kind;
    assign full = count_r == 6'(ERRQ_DEPTH);
    // a read entry stays while its cause persists
    assign pop = err_read && count_r != 6'h00 && !ERR_COND_HOLD;
    assign push_ok = push && (!full || pop);
    assign last_ptr = (wr_ptr_r == '0) ? PW'(ERRQ_DEPTH - 1)
                                       : wr_ptr_r - PW'(1);

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(ERRQ_DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // entry storage; a push beyond the depth turns the newest into overflow
    always_ff @(posedge SYS_CLK) begin
        if (push_ok) begin
            errq_mem[wr_ptr_r] <= push_kind;
        end else if (push) begin
            errq_mem[last_ptr] <= SDSR_ERR_QUEUE_OVERFLOW;
        end
    end

    // pointers; preset does not touch them, clear-status empties them
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN || clear_status) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            count_r <= 6'h00;
        end else begin
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push_ok) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            count_r <= count_r + 6'(push_ok) - 6'(pop);
        end
    end

    assign ERR_QUEUE_EMPTY = count_r == 6'h00;
    assign ERR_COUNT = count_r;

    function automatic logic [15:0] code_of(input sdsr_err_e k);
        case (k)
            SDSR_ERR_BAD_CHAR: code_of = `SDSR_CODE_BAD_CHAR;
            SDSR_ERR_SYNTAX: code_of = `SDSR_CODE_SYNTAX;
            SDSR_ERR_BAD_SEP: code_of = `SDSR_CODE_BAD_SEP;
            SDSR_ERR_MISSING_PARAM: code_of = `SDSR_CODE_MISSING_PARAM;
            SDSR_ERR_BAD_HEADER: code_of = `SDSR_CODE_BAD_HEADER;
            SDSR_ERR_NUM_OVERFLOW: code_of = `SDSR_CODE_NUM_OVERFLOW;
            SDSR_ERR_OUT_OF_RANGE: code_of = `SDSR_CODE_OUT_OF_RANGE;
            SDSR_ERR_QUEUE_OVERFLOW: code_of = `SDSR_CODE_QUEUE_OVERFLOW;
            default: code_of = 16'h0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // replies

    sdsr_rsp_s rsp_nxt;
    logic rsp_valid_nxt;
    sdsr_err_e head_kind;

    // reading an empty queue yields kind none and code 0
    assign head_kind = (count_r == 6'h00) ? SDSR_ERR_NONE
                                          : errq_mem[rd_ptr_r];

    // reply value per query; set commands and failures give no reply
    always_comb begin
        rsp_nxt = '0;
        rsp_valid_nxt = take && !cmd_err;
        case (CMD.op)
            SDSR_OP_OUT_DET_Q: begin
                if (CMD.chan_given) begin
                    rsp_nxt.value = {31'h0,
                        out_det[3'(CMD.chan - 8'h01)]};
                end else begin
                    rsp_nxt.value = 32'(out_det);
                end
            end
            SDSR_OP_OPER_COND_Q: rsp_nxt.value = 32'h0;
            SDSR_OP_OPER_EVENT_Q: rsp_nxt.value = 32'h0;
            SDSR_OP_OPER_ENAB_Q: rsp_nxt.value = 32'(oper_enab_r);
            SDSR_OP_QUES_COND_Q: rsp_nxt.value = 32'(ques_cond);
            SDSR_OP_QUES_EVENT_Q: rsp_nxt.value = 32'(ques_event_r);
            SDSR_OP_QUES_ENAB_Q: rsp_nxt.value = 32'(ques_enab_r);
            SDSR_OP_VERS_Q: rsp_nxt.value = VERSION;
            SDSR_OP_ERR_Q: begin
                rsp_nxt.is_error = 1'b1;
                rsp_nxt.err_code = code_of(head_kind);
                rsp_nxt.err_kind = head_kind;
                rsp_nxt.value = {{16{rsp_nxt.err_code[15]}}, rsp_nxt.err_code};
            end
            default: begin
                rsp_valid_nxt = 1'b0;
            end
        endcase
    end

    // reply stands one cycle behind the command, as a one-cycle pulse
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            RSP_VALID <= 1'b0;
            RSP <= '0;
        end else begin
            RSP_VALID <= rsp_valid_nxt;
            if (rsp_valid_nxt) begin
                RSP <= rsp_nxt;
            end
        end
    end

endmodule
`default_nettype wire

/* test/sdsr_host_model.sv */
// sdsr_host_model: host side that issues decoded commands and parse errors.
// assumes: one clock shared with the block; requests start 1 ns after a rise.
`timescale 1ns/1ps
`default_nettype none

module sdsr_host_model
    import sdsr_pkg::*;
(
    // clock
    input wire logic clk,
    // requests to the block
    output var logic cmd_valid,
    output var sdsr_cmd_s cmd,
    output var logic perr_valid,
    output var sdsr_err_e perr_kind,
    output var logic err_cond_hold,
    // replies
    input wire logic rsp_valid,
    input wire sdsr_rsp_s rsp
);
    logic hold_r = 1'b0;

    // pulses idle low; hold level is set by the bench
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        perr_valid = 1'b0;
        perr_kind = SDSR_ERR_NONE;
    end
    assign err_cond_hold = hold_r;

    ////////////////////////////////////////////////////////////////////////
    // one command; the reply is looked at in the cycle after the taking edge
    task automatic send(input sdsr_op_e op, input logic cg,
                        input logic [7:0] ch, input logic pg,
                        input logic [31:0] p, output logic got,
                        output sdsr_rsp_s r);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd = sdsr_cmd_s'{op, cg, ch, pg, p};
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        got = rsp_valid;
        r = rsp;
    endtask

    // one parse error pulse
    task automatic perr(input sdsr_err_e kind);
        @(posedge clk);
        #1;
        perr_valid = 1'b1;
        perr_kind = kind;
        @(posedge clk);
        #1;
        perr_valid = 1'b0;
    endtask
endmodule

`default_nettype wire

/* test/sdsr_top_assertions.sv */
// sdsr_checker: port-level relations of the status reporting block.
// assumes: bound to sdsr_top; stimulus never overlaps reset.
`timescale 1ns/1ps
`default_nettype none

module sdsr_checker
    import sdsr_pkg::*;
#(
    parameter int NUM_OUT = 6,
    parameter int ERRQ_DEPTH = 30
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // inputs watched
    input wire logic IN_LOSS,
    input wire logic CMD_VALID,
    input wire sdsr_cmd_s CMD,
    input wire logic PERR_VALID,
    input wire logic ERR_COND_HOLD,
    // outputs watched
    input wire logic RSP_VALID,
    input wire sdsr_rsp_s RSP,
    input wire logic ERR_QUEUE_EMPTY,
    input wire logic [5:0] ERR_COUNT
);
    // a command counts only without a parse error beside it
    wire logic take = CMD_VALID && !PERR_VALID;
    wire logic [5:0] depth = 6'(ERRQ_DEPTH);

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    ////////////////////////////////////////////////////////////////////////
    oper_zero_a: assert property (
        take && CMD.op inside {SDSR_OP_OPER_COND_Q, SDSR_OP_OPER_EVENT_Q}
        |=> RSP_VALID && RSP.value == 32'h0) else $error("oper read not zero");
    cond_bits_a: assert property (
        take && CMD.op == SDSR_OP_QUES_COND_Q |=> RSP_VALID
        && RSP.value[31:11] == 21'h0 && RSP.value[8:0] == 9'h0)
        else $error("unused condition bit set");
    input_loss_a: assert property (
        IN_LOSS [*4] ##0 (take && CMD.op == SDSR_OP_OUT_DET_Q
        && !CMD.chan_given) |=> RSP.value == 32'h3f)
        else $error("input loss composite wrong");
    bad_chan_a: assert property (
        take && CMD.op == SDSR_OP_OUT_DET_Q && CMD.chan_given
        && !(CMD.chan inside {[8'h01:8'h06]}) |=> !RSP_VALID)
        else $error("bad channel answered");
    err_push_a: assert property (
        PERR_VALID && ERR_COUNT < depth
        |=> ERR_COUNT == $past(ERR_COUNT) + 6'h1)
        else $error("error not counted");
    err_full_a: assert property (
        ERR_COUNT == depth && PERR_VALID |=> ERR_COUNT == depth)
        else $error("queue count past depth");
    err_hold_a: assert property (
        take && CMD.op == SDSR_OP_ERR_Q && ERR_COND_HOLD
        |=> $stable(ERR_COUNT))
        else $error("held error removed");
    preset_keep_a: assert property (
        take && CMD.op == SDSR_OP_PRESET |=> $stable(ERR_COUNT))
        else $error("preset touched queue");
    clear_empty_a: assert property (
        take && CMD.op == SDSR_OP_CLEAR_STATUS
        |=> ERR_QUEUE_EMPTY && ERR_COUNT == 6'h0)
        else $error("queue not cleared");
    reply_cause_a: assert property (
        RSP_VALID |-> $past(take)) else $error("reply without command");
endmodule

bind sdsr_top sdsr_checker #(.NUM_OUT(NUM_OUT), .ERRQ_DEPTH(ERRQ_DEPTH))
    u_chk (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .IN_LOSS(IN_LOSS), .CMD_VALID(CMD_VALID),
    .CMD(CMD), .PERR_VALID(PERR_VALID), .ERR_COND_HOLD(ERR_COND_HOLD),
    .RSP_VALID(RSP_VALID), .RSP(RSP), .ERR_QUEUE_EMPTY(ERR_QUEUE_EMPTY),
    .ERR_COUNT(ERR_COUNT));

`default_nettype wire

/* test/testbench.sv */
// testbench: command sequences against the status reporting block.
// assumes: the host model drives the command port; detectors driven here.
`timescale 1ns/1ps
`default_nettype none
`include "sdsr_map.svh"

module testbench
    import sdsr_pkg::*;
;
    logic sys_clk, rstn, in_loss, cmd_valid, perr_valid, hold, rsp_valid;
    logic ques_summary, err_queue_empty, got;
    logic [5:0] out_loss, err_count;
    sdsr_cmd_s cmd;
    sdsr_err_e perr_kind;
    sdsr_rsp_s rsp_w, rsp;
    int num_errors = 0;
    int tests_run = 0;
    sdsr_err_e kinds[6] = '{SDSR_ERR_BAD_CHAR, SDSR_ERR_SYNTAX,
        SDSR_ERR_BAD_SEP, SDSR_ERR_MISSING_PARAM, SDSR_ERR_BAD_HEADER,
        SDSR_ERR_NUM_OVERFLOW};
    logic [15:0] codes[6] = '{`SDSR_CODE_BAD_CHAR, `SDSR_CODE_SYNTAX,
        `SDSR_CODE_BAD_SEP, `SDSR_CODE_MISSING_PARAM, `SDSR_CODE_BAD_HEADER,
        `SDSR_CODE_NUM_OVERFLOW};

    // version set apart from the default so a stuck constant shows
    sdsr_top #(.VERSION(32'h0000_0002)) u_sdsr_top (.SYS_CLK(sys_clk),
        .RSTN(rstn), .IN_LOSS(in_loss), .OUT_LOSS(out_loss),
        .CMD_VALID(cmd_valid), .CMD(cmd), .PERR_VALID(perr_valid),
        .PERR_KIND(perr_kind), .ERR_COND_HOLD(hold), .RSP_VALID(rsp_valid),
        .RSP(rsp_w), .QUES_SUMMARY(ques_summary),
        .ERR_QUEUE_EMPTY(err_queue_empty), .ERR_COUNT(err_count));
    sdsr_host_model u_sdsr_host_model (.clk(sys_clk), .cmd_valid(cmd_valid),
        .cmd(cmd), .perr_valid(perr_valid), .perr_kind(perr_kind),
        .err_cond_hold(hold), .rsp_valid(rsp_valid), .rsp(rsp_w));

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ask(input sdsr_op_e op, input logic cg,
                       input logic [7:0] ch, input logic [31:0] p);
        u_sdsr_host_model.send(op, cg, ch, 1'b1, p, got, rsp);
    endtask

    // read the oldest entry, popped unless hold is set or the queue is empty, and compare its code
    task automatic errq(input logic [15:0] code);
        ask(SDSR_OP_ERR_Q, 1'b0, 8'h00, 32'h0);
        check(32'(rsp.err_code), 32'(code));
        check(rsp.value, {{16{code[15]}}, code});
    endtask

    // detectors pass two syncs plus the event and summary stages, so allow margin
    task automatic set_det(input logic i, input logic [5:0] o);
        @(posedge sys_clk);
        #1;
        in_loss = i;
        out_loss = o;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog well past the few hundred cycles the sequence needs
    initial begin
        #(40 * 20000);
        num_errors++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        in_loss = 1'b0;
        out_loss = 6'h00;
        repeat (5) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(32'({rsp_valid, ques_summary, err_queue_empty}), 32'h1);
        set_det(1'b0, 6'h28);
        ask(SDSR_OP_OUT_DET_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'd40);
        for (int i = 1; i <= 6; i++) begin
            ask(SDSR_OP_OUT_DET_Q, 1'b1, 8'(i), 32'h0);
            check(rsp.value, 32'(out_loss[i-1]));
        end
        repeat (2) begin
            ask(SDSR_OP_QUES_COND_Q, 1'b0, 8'h00, 32'h0);
            check(rsp.value, 32'h0400);
        end
        set_det(1'b1, 6'h00);
        ask(SDSR_OP_OUT_DET_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'd63);
        ask(SDSR_OP_QUES_COND_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h0600);
        ask(SDSR_OP_OPER_COND_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h0);
        ask(SDSR_OP_OPER_EVENT_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h0);
        set_det(1'b0, 6'h00);
        u_sdsr_host_model.perr(SDSR_ERR_BAD_CHAR);
        ask(SDSR_OP_CLEAR_STATUS, 1'b0, 8'h00, 32'h0);
        check(32'(err_queue_empty), 32'h1);
        ask(SDSR_OP_OUT_DET_Q, 1'b1, 8'h07, 32'h0);
        check(32'(got), 32'h0);
        ask(SDSR_OP_OPER_ENAB_SET, 1'b0, 8'h00, 32'h1234);
        ask(SDSR_OP_OPER_ENAB_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h1234);
        ask(SDSR_OP_QUES_ENAB_SET, 1'b0, 8'h00, 32'd32767);
        ask(SDSR_OP_QUES_ENAB_SET, 1'b0, 8'h00, 32'd32768);
        ask(SDSR_OP_QUES_ENAB_SET, 1'b0, 8'h00, 32'h0001_0000);
        u_sdsr_host_model.send(SDSR_OP_QUES_ENAB_SET, 1'b0, 8'h00, 1'b0,
                               32'h0, got, rsp);
        ask(SDSR_OP_QUES_ENAB_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h7fff);
        ask(SDSR_OP_PRESET, 1'b0, 8'h00, 32'h0);
        check(32'(err_count), 32'h4);
        ask(SDSR_OP_QUES_ENAB_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h0);
        ask(SDSR_OP_OPER_ENAB_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h0);
        errq(`SDSR_CODE_OUT_OF_RANGE);
        errq(`SDSR_CODE_OUT_OF_RANGE);
        errq(`SDSR_CODE_NUM_OVERFLOW);
        errq(`SDSR_CODE_MISSING_PARAM);
        // an input-only mask must not pass an output event through
        ask(SDSR_OP_QUES_ENAB_SET, 1'b0, 8'h00, 32'h0200);
        set_det(1'b0, 6'h01);
        check(32'(ques_summary), 32'h0);
        ask(SDSR_OP_QUES_ENAB_SET, 1'b0, 8'h00, 32'h7c00);
        repeat (3) @(posedge sys_clk);
        #1;
        check(32'(ques_summary), 32'h1);
        ask(SDSR_OP_QUES_EVENT_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h0400);
        repeat (3) @(posedge sys_clk);
        #1;
        check(32'(ques_summary), 32'h0);
        set_det(1'b0, 6'h00);
        foreach (kinds[i]) u_sdsr_host_model.perr(kinds[i]);
        u_sdsr_host_model.hold_r = 1'b1;
        errq(codes[0]);
        check(32'(err_count), 32'h6);
        u_sdsr_host_model.hold_r = 1'b0;
        foreach (codes[i]) errq(codes[i]);
        errq(16'h0000);
        check(32'(err_queue_empty), 32'h1);
        repeat (31) u_sdsr_host_model.perr(SDSR_ERR_BAD_CHAR);
        check(32'(err_count), 32'd30);
        repeat (29) errq(`SDSR_CODE_BAD_CHAR);
        errq(`SDSR_CODE_QUEUE_OVERFLOW);
        ask(SDSR_OP_VERS_Q, 1'b0, 8'h00, 32'h0);
        check(rsp.value, 32'h0000_0002);
        print_verdict();
    end
endmodule

`default_nettype wire
